// *** bench/eprp_host_model.sv ***
// Host model that toggles the channel enable pins
`timescale 1ns/100ps
module eprp_host_model #(
   parameter int PULSE_CYC = 6
) (
   input wire logic aclk,
   output logic [2:0] channel_toggle_pin
);
   initial channel_toggle_pin = 3'h0;
   // Called just after an edge; sets a level and holds it
   task automatic drive(input int ch, input logic v, input int hold);
      channel_toggle_pin[ch] <= v;
      repeat (hold) @(posedge aclk);
   endtask
   // lows of 60 ns, highs far below the timeout
   task automatic pulses(input int ch, input int n);
      for (int i = 0; i < n; i++) begin
         drive(ch, 1'b0, PULSE_CYC);
         drive(ch, 1'b1, PULSE_CYC);
      end
   endtask
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the triple reference programmer
`timescale 1ns/100ps
module tb;
   localparam int TFN = 50;
   localparam int TOFF = 80;
   localparam int BLANK = 10;
   localparam int SWIN = 40;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_wvalid = 1'b0;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_wready;
   logic s_axi_bready = 1'b0;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   logic [2:0] channel_toggle_pin;
   logic mode_pin = 1'b0;
   logic rt_tied_supply = 1'b0;
   logic uvlo_in = 1'b0;
   logic tsd_in = 1'b0;
   logic [2:0] vout_rise_ok = 3'h0;
   logic [2:0] vout_fall_bad = 3'h0;
   logic [11:0] ref_level;
   logic [2:0] chan_active;
   logic [2:0] soft_start;
   logic [2:0] burst_en;
   logic sync_active;
   logic sw_tick;
   logic power_good_flag_o;
   logic power_good_flag_oe;
   logic irq;
   int miscompares = 0;
   int samples_checked = 0;

   always #5 aclk = ~aclk;

   eprp_top #(.TFN_CYC(TFN), .TOFF_CYC(TOFF), .BLANK_CYC(BLANK),
      .SYNC_WIN_CYC(SWIN)) i_eprp_top (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .channel_toggle_pin(channel_toggle_pin),
      .mode_pin(mode_pin), .rt_tied_supply(rt_tied_supply),
      .uvlo_in(uvlo_in), .tsd_in(tsd_in), .vout_rise_ok(vout_rise_ok),
      .vout_fall_bad(vout_fall_bad), .ref_level(ref_level),
      .chan_active(chan_active), .soft_start(soft_start),
      .burst_en(burst_en), .sync_active(sync_active), .sw_tick(sw_tick),
      .power_good_flag_o(power_good_flag_o),
      .power_good_flag_oe(power_good_flag_oe), .irq(irq));

   eprp_host_model i_eprp_host_model (.aclk(aclk),
      .channel_toggle_pin(channel_toggle_pin));

   task automatic end_sim();
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   // Bounded waits that run out end the run as a failure
   task automatic timed_out(input int n);
      if (n >= 300) begin
         miscompares++;
         end_sim();
      end
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 300; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      timed_out(n);
      check(s_axi_bresp, er);
      @(posedge aclk);
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
      input logic [1:0] er);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 300; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      timed_out(n);
      check(s_axi_rdata, ed);
      check(s_axi_rresp, er);
      @(posedge aclk);
   endtask

   // Cycles between two switching ticks
   task automatic tick_gap(input int exp);
      int n;
      int g;
      for (n = 0; n < 300; n++) begin
         @(posedge aclk);
         if (sw_tick === 1'b1) break;
      end
      timed_out(n);
      g = 0;
      for (n = 0; n < 300; n++) begin
         @(posedge aclk);
         g++;
         if (sw_tick === 1'b1) break;
      end
      timed_out(n);
      check(g, exp);
   endtask

   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      check(ref_level, 12'hFFF);
      check({chan_active, power_good_flag_oe}, 4'h1);
      check({power_good_flag_o, irq}, 2'h0);
      axi_rd(8'h00, 32'h32, 2'h0);
      axi_rd(8'h0C, 32'h0, 2'h0);
      axi_rd(8'h10, 32'h0, 2'h2);
      axi_wr(8'h10, 32'hFF, 2'h2);
      i_eprp_host_model.drive(0, 1'b1, 0);
      i_eprp_host_model.drive(1, 1'b1, TFN + 10);
      check({chan_active, soft_start}, 6'h1B);
      i_eprp_host_model.pulses(0, 3);
      i_eprp_host_model.pulses(1, 17);
      repeat (TFN + 10) @(posedge aclk);
      check(ref_level, 12'hF0C);
      vout_rise_ok <= 3'h3;
      repeat (5) @(posedge aclk);
      check({soft_start, power_good_flag_oe}, 4'h0);
      i_eprp_host_model.pulses(0, 2);
      repeat (TFN + 10) @(posedge aclk);
      check({ref_level, soft_start}, 15'h7868);
      axi_rd(8'h08, 32'h3, 2'h0);
      axi_wr(8'h0C, 32'h1, 2'h0);
      repeat (3) @(posedge aclk);
      check(irq, 1'b1);
      axi_wr(8'h08, 32'h3, 2'h0);
      repeat (3) @(posedge aclk);
      check(irq, 1'b0);
      vout_rise_ok <= 3'h0;
      vout_fall_bad <= 3'h1;
      repeat (BLANK - 5) @(posedge aclk);
      vout_fall_bad <= 3'h0;
      repeat (5) @(posedge aclk);
      check(power_good_flag_oe, 1'b0);
      vout_fall_bad <= 3'h1;
      repeat (BLANK + 10) @(posedge aclk);
      check(power_good_flag_oe, 1'b1);
      vout_fall_bad <= 3'h0;
      vout_rise_ok <= 3'h3;
      mode_pin <= 1'b1;
      repeat (5) @(posedge aclk);
      check(burst_en, 3'h3);
      for (int i = 0; i < 9; i++) begin
         mode_pin <= ~mode_pin;
         repeat (15) @(posedge aclk);
      end
      check({sync_active, burst_en}, 4'h8);
      repeat (SWIN + 10) @(posedge aclk);
      check({sync_active, burst_en}, 4'h0);
      rt_tied_supply <= 1'b1;
      tick_gap(44);
      rt_tied_supply <= 1'b0;
      axi_wr(8'h00, 32'h14, 2'h0);
      tick_gap(20);
      uvlo_in <= 1'b1;
      repeat (5) @(posedge aclk);
      check({chan_active, ref_level}, 15'h0F0D);
      uvlo_in <= 1'b0;
      tsd_in <= 1'b1;
      vout_rise_ok <= 3'h0;
      repeat (5) @(posedge aclk);
      tsd_in <= 1'b0;
      repeat (5) @(posedge aclk);
      check({soft_start, ref_level}, 15'h3F0D);
      mode_pin <= 1'b1;
      i_eprp_host_model.drive(0, 1'b0, TOFF + 10);
      check(chan_active, 3'h2);
      i_eprp_host_model.drive(0, 1'b1, 5);
      check({soft_start[0], ref_level}, 13'h1F0F);
      check(burst_en, 3'h0);
      vout_rise_ok <= 3'h3;
      repeat (5) @(posedge aclk);
      check(burst_en, 3'h3);
      end_sim();
   end
endmodule

// *** core/eprp_chan.sv ***
// One channel: toggle counter, level latch, soft-start, power good
`timescale 1ns/100ps
`include "eprp_consts.svh"

module eprp_chan
   import eprp_pkg::*;
#(
   parameter int TFN_CYC = `EPRP_TFN_US * `EPRP_CLK_MHZ,
   parameter int TOFF_CYC = `EPRP_TOFF_US * `EPRP_CLK_MHZ,
   parameter int BLANK_CYC = (`EPRP_BLANK_NS * `EPRP_CLK_MHZ + 999) / 1000,
   parameter int CNT_W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic toggle_s,
   input wire logic rise_ok_s,
   input wire logic fall_bad_s,
   input wire logic uvlo_s,
   input wire logic tsd_s,
   output logic [3:0] level_q,
   output logic active_q,
   output logic ss_q,
   output logic good_q,
   output logic latch_q,
   output logic off_q
);

   eprp_chan_st_t st_q, st_d;
   logic [3:0] cnt_q, cnt_d, level_d;
   logic latch_d, off_d, turn_on;
   logic tog_prev_q, tsd_prev_q;
   logic [CNT_W-1:0] hi_q, lo_q, bad_q;

   wire fall = tog_prev_q & ~toggle_s;
   wire tmo = toggle_s && (hi_q == CNT_W'(TFN_CYC - 1));
   wire shut = !toggle_s && (lo_q == CNT_W'(TOFF_CYC - 1));
   wire tsd_exit = tsd_prev_q & ~tsd_s;
   wire run_ok = (st_q != chan_off) && !uvlo_s && !tsd_s;
   wire bad_full = bad_q == CNT_W'(BLANK_CYC - 1);
   wire ss_set = turn_on | (tsd_exit & (st_q != chan_off));

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      level_d = level_q;
      latch_d = 1'b0;
      off_d = 1'b0;
      turn_on = 1'b0;
      unique case (st_q)
         chan_off: begin
            if (toggle_s) begin
               st_d = chan_run;
               cnt_d = `EPRP_LEVEL_FS;
               level_d = `EPRP_LEVEL_FS;
               turn_on = 1'b1;
            end
         end
         chan_run: begin
            if (fall) begin
               st_d = chan_seq;
               cnt_d = `EPRP_LEVEL_FS - 4'h1;
            end else if (shut) begin
               st_d = chan_off;
               off_d = 1'b1;
            end
         end
         chan_seq: begin
            if (fall) begin
               if (cnt_q != `EPRP_LEVEL_MIN)
                  cnt_d = cnt_q - 4'h1;
            end else if (tmo) begin
               st_d = chan_run;
               level_d = cnt_q;
               cnt_d = `EPRP_LEVEL_FS;
               latch_d = 1'b1;
            end else if (shut) begin
               st_d = chan_off;
               off_d = 1'b1;
            end
         end
         default: st_d = chan_off;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= chan_off;
         cnt_q <= `EPRP_LEVEL_FS;
         level_q <= `EPRP_LEVEL_FS;
         latch_q <= 1'b0;
         off_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         level_q <= level_d;
         latch_q <= latch_d;
         off_q <= off_d;
      end
   end

   // Saturating high and low timers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hi_q <= '0;
         lo_q <= '0;
         tog_prev_q <= 1'b0;
         tsd_prev_q <= 1'b0;
      end else begin
         hi_q <= !toggle_s ? '0 : (tmo ? hi_q : hi_q + 1'b1);
         lo_q <= toggle_s ? '0 : (shut ? lo_q : lo_q + 1'b1);
         tog_prev_q <= toggle_s;
         tsd_prev_q <= tsd_s;
      end
   end

   // Only turn-on or thermal exit ramps
   always_ff @(posedge aclk) begin
      if (!aresetn)
         ss_q <= 1'b0;
      else
         ss_q <= ss_set | (ss_q & ~rise_ok_s & ~off_d);
   end

   // Dip must outlast the blanking time
   // Fall below lower threshold drops good
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bad_q <= '0;
         good_q <= 1'b0;
         active_q <= 1'b0;
      end else begin
         bad_q <= !(fall_bad_s && run_ok) ? '0 :
                  (bad_full ? bad_q : bad_q + 1'b1);
         good_q <= run_ok & ~(fall_bad_s & bad_full) &
                   (good_q | rise_ok_s);
         active_q <= run_ok;
      end
   end

   a_count_down: assert property (
      @(posedge aclk) disable iff (!aresetn)
      st_q == chan_seq && fall && cnt_q != 4'h0
      |=> cnt_q == $past(cnt_q) - 4'h1)
      else $error("counter did not step down on falling edge");

   a_count_sat: assert property (
      @(posedge aclk) disable iff (!aresetn)
      st_q == chan_seq && fall && cnt_q == 4'h0 |=> cnt_q == 4'h0)
      else $error("counter wrapped past lowest code");

   a_latch_value: assert property (
      @(posedge aclk) disable iff (!aresetn)
      st_q == chan_seq && tmo && !fall
      |=> latch_q && level_q == $past(cnt_q) && cnt_q == 4'hF)
      else $error("timeout did not latch count and reset counter");

   a_restore_fs: assert property (
      @(posedge aclk) disable iff (!aresetn)
      st_q == chan_off && toggle_s |=> level_q == 4'hF && ss_q)
      else $error("turn-on did not restore full scale with ramp");

   a_no_ramp: assert property (
      @(posedge aclk) disable iff (!aresetn)
      latch_q && !$past(tsd_exit) |-> !$rose(ss_q))
      else $error("latched code started a soft-start");

   a_uvlo_keep: assert property (
      @(posedge aclk) disable iff (!aresetn)
      uvlo_s && st_q == chan_run |=> level_q == $past(level_q))
      else $error("undervoltage changed the latched code");

   a_tsd_ramp: assert property (
      @(posedge aclk) disable iff (!aresetn)
      tsd_exit && st_q != chan_off |=> ss_q && level_q == $past(level_q))
      else $error("thermal exit did not restart soft-start");

   a_blank_dip: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $fell(good_q) && $past(run_ok) |-> $past(bad_full))
      else $error("short dip changed power good");

endmodule

// *** core/eprp_consts.svh ***
// Constants for the enable-pulse reference programmer
// Function
// - Level starts full scale, steps down per pulse
// - Counter decrements on each toggle falling edge
// - High for 125 us latches count, resets counter
// - Beyond fifteen edges, counter holds lowest code
// - Long low shuts down; rise restores full scale
// - Latch without shutdown skips soft-start
// - Each channel programmed only by own pin
// - Power good releases when all enabled reach 92%
// - Power good pulls low below 88% level
// - Dips shorter than 2 us are ignored
// - Mode pin high bursts, low skips pulses
// - Clock on mode pin syncs, forces pulse skip
// - Tied frequency pin gives fixed 2.25 MHz
// - Soft-start forces pulse skip until power good
// - Undervoltage lockout keeps latched codes
// - Thermal recovery keeps codes, restarts soft-start
`ifndef EPRP_CONSTS_SVH
`define EPRP_CONSTS_SVH

`define EPRP_CLK_MHZ 100
`define EPRP_TFN_US 125
`define EPRP_TOFF_US 170
`define EPRP_BLANK_NS 2000
`define EPRP_SYNC_WIN_NS 2000
`define EPRP_FIXED_KHZ 2250

`define EPRP_LEVEL_FS 4'hF
`define EPRP_LEVEL_MIN 4'h0

`define EPRP_OFF_CTRL 8'h00
`define EPRP_OFF_STATUS 8'h04
`define EPRP_OFF_ISTAT 8'h08
`define EPRP_OFF_IMASK 8'h0C

`define EPRP_CTRL_RST 8'h32
`define EPRP_IMASK_RST 8'h00
`define EPRP_EV_W 8

`define EPRP_ST_ACT_POS 12
`define EPRP_ST_SS_POS 15
`define EPRP_ST_PG_POS 18
`define EPRP_ST_SYNC_POS 19

`define EPRP_RESP_OK 2'h0
`define EPRP_RESP_SLVERR 2'h2

`endif

// *** core/eprp_pkg.sv ***
// Types shared by the reference programmer modules
package eprp_pkg;

   typedef enum logic [2:0] {
      chan_off = 3'b001,
      chan_run = 3'b010,
      chan_seq = 3'b100
   } eprp_chan_st_t;

endpackage

// *** core/eprp_top.sv ***
// Triple-channel reference programmer with AXI4-Lite registers
`timescale 1ns/100ps
`include "eprp_consts.svh"

module eprp_top
   import eprp_pkg::*;
#(
   parameter int TFN_CYC = `EPRP_TFN_US * `EPRP_CLK_MHZ,
   parameter int TOFF_CYC = `EPRP_TOFF_US * `EPRP_CLK_MHZ,
   parameter int BLANK_CYC = (`EPRP_BLANK_NS * `EPRP_CLK_MHZ + 999) / 1000,
   parameter int SYNC_WIN_CYC = `EPRP_SYNC_WIN_NS * `EPRP_CLK_MHZ / 1000,
   parameter int FIXED_DIV = `EPRP_CLK_MHZ * 1000 / `EPRP_FIXED_KHZ,
   parameter int NCH = 3,
   parameter int CNT_W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NCH-1:0] channel_toggle_pin,
   input wire logic mode_pin,
   input wire logic rt_tied_supply,
   input wire logic uvlo_in,
   input wire logic tsd_in,
   input wire logic [NCH-1:0] vout_rise_ok,
   input wire logic [NCH-1:0] vout_fall_bad,
   output logic [4*NCH-1:0] ref_level,
   output logic [NCH-1:0] chan_active,
   output logic [NCH-1:0] soft_start,
   output logic [NCH-1:0] burst_en,
   output logic sync_active,
   output logic sw_tick,
   output logic power_good_flag_o,
   output logic power_good_flag_oe,
   output logic irq
);

   localparam int SW = 3 * NCH + 4;
   localparam int EVW = `EPRP_EV_W;

   // Pin synchronisers
   logic [SW-1:0] sync1_q, sync2_q;
   wire [SW-1:0] pins_raw = {tsd_in, uvlo_in, rt_tied_supply, mode_pin,
                             vout_fall_bad, vout_rise_ok,
                             channel_toggle_pin};
   wire [NCH-1:0] tog_s = sync2_q[NCH-1:0];
   wire [NCH-1:0] rise_s = sync2_q[2*NCH-1:NCH];
   wire [NCH-1:0] fbad_s = sync2_q[3*NCH-1:2*NCH];
   wire mode_s = sync2_q[3*NCH];
   wire rt_s = sync2_q[3*NCH+1];
   wire uvlo_s = sync2_q[3*NCH+2];
   wire tsd_s = sync2_q[3*NCH+3];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= pins_raw;
         sync2_q <= sync1_q;
      end
   end

   // Per-channel programmers
   logic [NCH-1:0] good, latch_ev, off_ev;

   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi = gi + 1) begin : g_chan
         eprp_chan #(
            .TFN_CYC(TFN_CYC),
            .TOFF_CYC(TOFF_CYC),
            .BLANK_CYC(BLANK_CYC),
            .CNT_W(CNT_W)
         ) u_chan (
            .aclk(aclk),
            .aresetn(aresetn),
            .toggle_s(tog_s[gi]),
            .rise_ok_s(rise_s[gi]),
            .fall_bad_s(fbad_s[gi]),
            .uvlo_s(uvlo_s),
            .tsd_s(tsd_s),
            .level_q(ref_level[4*gi+3:4*gi]),
            .active_q(chan_active[gi]),
            .ss_q(soft_start[gi]),
            .good_q(good[gi]),
            .latch_q(latch_ev[gi]),
            .off_q(off_ev[gi])
         );
      end
   endgenerate

   // Power good aggregation
   wire all_good = (|chan_active) && (&(good | ~chan_active));
   logic pg_low_q;

   // Release only when every enabled is good
   // Any enabled channel low pulls flag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pg_low_q <= 1'b1;
         power_good_flag_oe <= 1'b1;
         power_good_flag_o <= 1'b0;
      end else begin
         pg_low_q <= ~all_good;
         power_good_flag_oe <= ~all_good;
         power_good_flag_o <= 1'b0;
      end
   end

   // Mode pin: sync detection and switching clock
   logic mode_prev_q;
   logic [CNT_W-1:0] gap_q, div_q;
   logic [7:0] ctrl_div_q;

   wire mode_edge = mode_prev_q ^ mode_s;
   wire mode_rise = ~mode_prev_q & mode_s;
   wire gap_full = gap_q == CNT_W'(SYNC_WIN_CYC);
   wire sync_start = mode_edge & ~gap_full & ~sync_active;
   // Zero divider from software would stall the clock; floor at 1
   wire [CNT_W-1:0] rt_lim = (ctrl_div_q == 8'h00) ? CNT_W'(1) :
                             CNT_W'(ctrl_div_q);
   wire [CNT_W-1:0] div_lim = rt_s ? CNT_W'(FIXED_DIV) : rt_lim;
   wire div_wrap = div_q >= div_lim - CNT_W'(1);
   wire tick_d = sync_active ? mode_rise : div_wrap;

   // Two edges within window mean sync
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_prev_q <= 1'b0;
         gap_q <= CNT_W'(SYNC_WIN_CYC);
         sync_active <= 1'b0;
      end else begin
         mode_prev_q <= mode_s;
         gap_q <= mode_edge ? '0 : (gap_full ? gap_q : gap_q + 1'b1);
         sync_active <= (sync_active & ~gap_full) | sync_start;
      end
   end

   // Internal oscillator, realigned by sync clock edges
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_q <= '0;
         sw_tick <= 1'b0;
      end else begin
         div_q <= (tick_d || (sync_active && mode_rise)) ? '0 :
                  div_q + 1'b1;
         sw_tick <= tick_d;
      end
   end

   // Mode level picks burst or skip
   always_ff @(posedge aclk) begin
      if (!aresetn)
         burst_en <= '0;
      else
         burst_en <= {NCH{mode_s & ~sync_active}} & ~soft_start &
                     chan_active;
   end

   // AXI4-Lite write path
   logic aw_full_q, w_full_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic [EVW-1:0] ist_q, imask_q;

   wire aw_hs = s_axi_awvalid & s_axi_awready;
   wire w_hs = s_axi_wvalid & s_axi_wready;
   wire b_done = s_axi_bvalid & s_axi_bready;
   wire wr_go = aw_full_q & w_full_q & ~s_axi_bvalid;
   wire aw_full_d = (aw_full_q | aw_hs) & ~b_done;
   wire w_full_d = (w_full_q | w_hs) & ~b_done;
   wire wa_ctrl = aw_addr_q == `EPRP_OFF_CTRL;
   wire wa_stat = aw_addr_q == `EPRP_OFF_STATUS;
   wire wa_ist = aw_addr_q == `EPRP_OFF_ISTAT;
   wire wa_imask = aw_addr_q == `EPRP_OFF_IMASK;
   wire wa_hit = wa_ctrl | wa_stat | wa_ist | wa_imask;
   wire wr_lane0 = wr_go & w_strb_q[0];
   wire [EVW-1:0] w1c = (wr_lane0 & wa_ist) ? w_data_q[EVW-1:0] : '0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         aw_full_q <= aw_full_d;
         w_full_q <= w_full_d;
         s_axi_awready <= ~aw_full_d;
         s_axi_wready <= ~w_full_d;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else begin
         if (aw_hs)
            aw_addr_q <= s_axi_awaddr;
         if (w_hs) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
      end
   end

   // Status is read-only; writes to it answer OKAY and are dropped
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `EPRP_RESP_OK;
      end else begin
         s_axi_bvalid <= wr_go | (s_axi_bvalid & ~s_axi_bready);
         if (wr_go)
            s_axi_bresp <= wa_hit ? `EPRP_RESP_OK : `EPRP_RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_div_q <= `EPRP_CTRL_RST;
         imask_q <= `EPRP_IMASK_RST;
      end else begin
         if (wr_lane0 & wa_ctrl)
            ctrl_div_q <= w_data_q[7:0];
         if (wr_lane0 & wa_imask)
            imask_q <= w_data_q[EVW-1:0];
      end
   end

   // Interrupt status: set wins over a same-cycle clear
   wire pg_fall = ~pg_low_q & ~all_good;
   wire [EVW-1:0] events = {sync_start, pg_fall, off_ev, latch_ev};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ist_q <= '0;
         irq <= 1'b0;
      end else begin
         ist_q <= (ist_q & ~w1c) | events;
         irq <= |(ist_q & imask_q);
      end
   end

   // AXI4-Lite read path
   wire [31:0] status_word = {12'h000, sync_active, ~pg_low_q,
                              soft_start, chan_active, ref_level};
   wire ra_ctrl = s_axi_araddr == `EPRP_OFF_CTRL;
   wire ra_stat = s_axi_araddr == `EPRP_OFF_STATUS;
   wire ra_ist = s_axi_araddr == `EPRP_OFF_ISTAT;
   wire ra_imask = s_axi_araddr == `EPRP_OFF_IMASK;
   wire ra_hit = ra_ctrl | ra_stat | ra_ist | ra_imask;
   wire [31:0] rd_mux = ra_ctrl ? {24'h000000, ctrl_div_q} :
                        ra_stat ? status_word :
                        ra_ist ? {24'h000000, ist_q} :
                        ra_imask ? {24'h000000, imask_q} :
                        32'h0000_0000;
   wire ar_hs = s_axi_arvalid & s_axi_arready;
   wire rvalid_d = ar_hs | (s_axi_rvalid & ~s_axi_rready);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `EPRP_RESP_OK;
      end else begin
         s_axi_arready <= ~rvalid_d;
         s_axi_rvalid <= rvalid_d;
         if (ar_hs) begin
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= ra_hit ? `EPRP_RESP_OK : `EPRP_RESP_SLVERR;
         end
      end
   end

   a_pin_sync: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $past(aresetn, 2) |-> tog_s == $past(channel_toggle_pin, 2))
      else $error("toggle pins not passed through two flops");

   a_pg_release: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !power_good_flag_oe |-> $past(|chan_active) &&
      $past(&(good | ~chan_active)))
      else $error("power good released with a channel not good");

   a_pg_pull: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (|(chan_active & ~good)) |=> power_good_flag_oe)
      else $error("power good not pulled low for a failing channel");

   a_burst_sel: assert property (
      @(posedge aclk) disable iff (!aresetn)
      burst_en[0] |-> $past(mode_s) && $past(chan_active[0]))
      else $error("burst chosen without mode pin high");

   a_sync_skip: assert property (
      @(posedge aclk) disable iff (!aresetn)
      sync_active |=> burst_en == '0)
      else $error("burst active during synchronisation");

   a_ss_skip: assert property (
      @(posedge aclk) disable iff (!aresetn)
      soft_start[1] |=> !burst_en[1])
      else $error("burst active during soft-start");

   a_fixed_gap: assert property (
      @(posedge aclk) disable iff (!aresetn)
      sw_tick && rt_s && !sync_active && $stable(rt_s)
      |=> !sw_tick [*8])
      else $error("fixed rate clock ticks too close");

   a_pg_idle: assert property (
      @(posedge aclk) disable iff (!aresetn)
      chan_active == '0 |=> power_good_flag_oe)
      else $error("power good released with no channel on");

   a_latch_flag: assert property (
      @(posedge aclk) disable iff (!aresetn)
      latch_ev[0] |=> ist_q[0])
      else $error("latch event not kept in status");

endmodule
